// File: core/dcs_dev.sv
// Channel control and status end: registers, arbiter, offset counters.
// Assumes the host holds each strobe one cycle and drains xfer words.
module dcs_dev
    import dcs_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst,
    dcs_if.dev        b
);
    // pend doubles as the busy bit: set by a request or forced start, cleared when its word is pushed into the buffer
    typedef struct packed {
        logic [CH_W-1:0]              sel;
        logic [NCH-1:0]               en;
        logic [NCH-1:0]               full;
        logic [NCH-1:0]               mid;
        logic [NCH-1:0]               pend;
        logic [NCH-1:0]               wrap;
        logic [NCH-1:0][BYTE_W-1:0]   cfg;
        logic [NCH-1:0][BASE_W-1:0]   base;
        logic [NCH-1:0][CNT_W-1:0]    size;
        logic [NCH-1:0][CNT_W-1:0]    offs;
        logic [BYTE_W-1:0]            rdata;
        dcs_xfer_s [1:0]              q;
        logic [1:0]                   cnt;
    } dcs_dev_s;

    dcs_dev_s s_r;
    dcs_dev_s s_nxt;

    logic              hit;
    logic              chv;
    logic [CH_W-1:0]   ch;
    logic [NCH-1:0]    force_v;
    logic [NCH-1:0]    elig;
    logic [NCH-1:0]    inten;
    logic [NCH-1:0]    minten;
    logic [NCH-1:0]    fset;
    logic [NCH-1:0]    mset;
    logic [CH_W-1:0]   g;
    logic              gv;
    logic              push;
    logic              pop;
    logic [1:0]        n;
    logic [CNT_W-1:0]  midv;
    logic [BYTE_W-1:0] rd;
    dcs_xfer_s         ent;

    always_comb begin
        // Defaults hold every register and leave all strobes idle
        s_nxt   = s_r;
        hit     = (b.sfr_page == SFR_PAGE);
        chv     = (s_r.sel != SEL_INVALID);
        ch      = s_r.sel;
        force_v = '0;
        fset    = '0;
        mset    = '0;
        g       = '0;
        gv      = 1'b0;
        n       = s_r.cnt;
        midv    = '0;
        ent     = '0;
        rd      = '0;

        // Software writes
        // Indirect registers need a valid selector; code 7 has no slot
        if (b.sfr_wr && hit) begin
            if (b.sfr_addr == A_SEL) begin
                s_nxt.sel = b.sfr_wdata[CH_W-1:0];
            end else if (b.sfr_addr == A_EN) begin
                s_nxt.en = b.sfr_wdata[NCH-1:0];
            end else if (b.sfr_addr == A_FULL) begin
                s_nxt.full = s_r.full & b.sfr_wdata[NCH-1:0];
            end else if (b.sfr_addr == A_MID) begin
                s_nxt.mid = s_r.mid & b.sfr_wdata[NCH-1:0];
            end else if (b.sfr_addr == A_BUSY) begin
                force_v = b.sfr_wdata[NCH-1:0];
            end else if (chv) begin
                if (b.sfr_addr == A_CFG) begin
                    s_nxt.cfg[ch] = b.sfr_wdata;
                end else if (b.sfr_addr == A_MODE) begin
                    s_nxt.wrap[ch] = b.sfr_wdata[MODE_WRAP];
                    // Region registers freeze while the channel waits for its grant
                end else if (!s_r.pend[ch]) begin
                    if (b.sfr_addr == A_BASEL) begin
                        s_nxt.base[ch][BYTE_W-1:0] = b.sfr_wdata;
                    end else if (b.sfr_addr == A_BASEH) begin
                        s_nxt.base[ch][BASE_W-1:BYTE_W] = b.sfr_wdata[BASE_W-BYTE_W-1:0];
                    end else if (b.sfr_addr == A_SIZEL) begin
                        s_nxt.size[ch][BYTE_W-1:0] = b.sfr_wdata;
                    end else if (b.sfr_addr == A_SIZEH) begin
                        s_nxt.size[ch][CNT_W-1:BYTE_W] = b.sfr_wdata[CNT_W-BYTE_W-1:0];
                    end else if (b.sfr_addr == A_OFFL) begin
                        s_nxt.offs[ch][BYTE_W-1:0] = b.sfr_wdata;
                    end else if (b.sfr_addr == A_OFFH) begin
                        s_nxt.offs[ch][CNT_W-1:BYTE_W] = b.sfr_wdata[CNT_W-BYTE_W-1:0];
                    end
                end
            end
        end

        // A request from a disabled channel is dropped, not remembered
        // Requests from enabled channels or forced starts
        s_nxt.pend = s_nxt.pend | (b.req & s_r.en) | force_v;

        // Stalled channels and unacknowledged full flags take no new grant
        for (int i = 0; i < NCH; i++) begin
            inten[i]  = s_r.cfg[i][CFG_INTEN];
            minten[i] = s_r.cfg[i][CFG_MINTEN];
            elig[i]   = s_r.pend[i] && !s_r.cfg[i][CFG_STALL] && !s_r.full[i];
        end

        // At most one grant per cycle
        // Channel 0 first
        for (int i = NCH - 1; i >= 0; i--) begin
            if (elig[i]) begin
                g  = CH_W'(i);
                gv = 1'b1;
            end
        end

        pop  = (s_r.cnt != 2'h0) && b.xfer_ready;
        push = gv && (s_r.cnt != BUF_DEPTH);

        // Flags compare the offset of the outgoing byte, before it advances
        if (push) begin
            ent.chan     = g;
            ent.addr     = s_r.base[g] + BASE_W'(s_r.offs[g]);
            s_nxt.pend[g] = 1'b0;
            midv = (s_r.size[g] >> 1) + CNT_W'(s_r.size[g][0]);
            if (s_r.offs[g] == midv) begin
                mset[g] = 1'b1;
            end
            if (s_r.offs[g] == s_r.size[g] - CNT_W'(1)) begin
                fset[g] = 1'b1;
                // Without wrap the offset parks at size-1 and the full flag holds the channel
                if (s_r.wrap[g]) begin
                    s_nxt.offs[g] = '0;
                end
            end else begin
                s_nxt.offs[g] = s_r.offs[g] + CNT_W'(1);
            end
        end

        // Set beats a simultaneous software clear
        s_nxt.full = s_nxt.full | fset;
        s_nxt.mid  = s_nxt.mid | mset;

        // Two-entry buffer toward the datapath
        // Push waits for a free slot, so a stalled sink loses no word
        // Pop and push in one cycle keep the count; the new word becomes the head
        if (pop) begin
            s_nxt.q[0] = s_r.q[1];
            n = n - 2'h1;
        end
        if (push) begin
            s_nxt.q[n[0]] = ent;
            n = n + 2'h1;
        end
        s_nxt.cnt = n;

        // Read mux; unmapped or invalid selector reads zero
        // Seven channels only, so bit 7 of enable, flags and busy reads zero
        if (b.sfr_addr == A_SEL) begin
            rd = BYTE_W'(s_r.sel);
        end else if (b.sfr_addr == A_EN) begin
            rd = BYTE_W'(s_r.en);
        end else if (b.sfr_addr == A_FULL) begin
            rd = BYTE_W'(s_r.full);
        end else if (b.sfr_addr == A_MID) begin
            rd = BYTE_W'(s_r.mid);
        end else if (b.sfr_addr == A_BUSY) begin
            rd = BYTE_W'(s_r.pend);
        end else if (!chv) begin
            rd = '0;
        end else if (b.sfr_addr == A_CFG) begin
            rd = s_r.cfg[ch];
        end else if (b.sfr_addr == A_MODE) begin
            rd = BYTE_W'(s_r.wrap[ch]);
        end else if (b.sfr_addr == A_BASEL) begin
            rd = s_r.base[ch][BYTE_W-1:0];
        end else if (b.sfr_addr == A_BASEH) begin
            rd = BYTE_W'(s_r.base[ch] >> BYTE_W);
        end else if (b.sfr_addr == A_SIZEL) begin
            rd = s_r.size[ch][BYTE_W-1:0];
        end else if (b.sfr_addr == A_SIZEH) begin
            rd = BYTE_W'(s_r.size[ch] >> BYTE_W);
        end else if (b.sfr_addr == A_OFFL) begin
            rd = s_r.offs[ch][BYTE_W-1:0];
        end else if (b.sfr_addr == A_OFFH) begin
            rd = BYTE_W'(s_r.offs[ch] >> BYTE_W);
        end
        if (b.sfr_rd && hit) begin
            s_nxt.rdata = rd;
        end
    end

    // Synchronous reset clears registers, flags, read data and buffer
    always_ff @(posedge clk) begin
        if (rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign b.sfr_rdata  = s_r.rdata;
    assign b.xfer_valid = (s_r.cnt != 2'h0);
    assign b.xfer       = s_r.q[0];
    // Level request; drops only on reset or when software clears a flag or its interrupt enable
    assign b.irq        = |((s_r.full & inten) | (s_r.mid & minten));
endmodule

// File: core/dcs_host.sv
// CPU-side end: turns user commands into one-cycle register strobes,
// registers peripheral requests and hands transfer words to the user.
module dcs_host
    import dcs_pkg::*;
(
    input  wire logic               clk,
    input  wire logic               rst,
    input  wire logic               cmd_valid,
    input  wire logic               cmd_we,
    input  wire logic [PAGE_W-1:0]  cmd_page,
    input  wire logic [BYTE_W-1:0]  cmd_addr,
    input  wire logic [BYTE_W-1:0]  cmd_wdata,
    output      logic               cmd_ready,
    output      logic               rsp_valid,
    output      logic [BYTE_W-1:0]  rsp_rdata,
    input  wire logic [NCH-1:0]     periph_req,
    output      logic               xfer_valid,
    input  wire logic               xfer_ready,
    output      logic [CH_W-1:0]    xfer_chan,
    output      logic [BASE_W-1:0]  xfer_addr,
    output      logic               irq,
    dcs_if.host                     b
);
    typedef enum logic [1:0] {
        H_IDLE = 2'h0,
        H_ACC  = 2'h1,
        H_CAP  = 2'h3
    } dcs_hst_e;

    typedef struct packed {
        dcs_hst_e           st;
        logic               we;
        logic [PAGE_W-1:0]  page;
        logic [BYTE_W-1:0]  addr;
        logic [BYTE_W-1:0]  wdata;
        logic               rv;
        logic [BYTE_W-1:0]  rdata;
        logic [NCH-1:0]     req;
    } dcs_hst_s;

    dcs_hst_s s_r;
    dcs_hst_s s_nxt;

    always_comb begin
        s_nxt     = s_r;
        s_nxt.rv  = 1'b0;
        s_nxt.req = periph_req;
        case (s_r.st)
            H_IDLE: begin
                // Order of configuration writes is the user's duty
                if (cmd_valid) begin
                    s_nxt.we    = cmd_we;
                    s_nxt.page  = cmd_page;
                    s_nxt.addr  = cmd_addr;
                    s_nxt.wdata = cmd_wdata;
                    s_nxt.st    = H_ACC;
                end
            end
            H_ACC: begin
                s_nxt.st = H_CAP;
            end
            H_CAP: begin
                if (!s_r.we) begin
                    s_nxt.rdata = b.sfr_rdata;
                end
                s_nxt.rv = 1'b1;
                s_nxt.st = H_IDLE;
            end
            default: begin
                s_nxt.st = H_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign cmd_ready    = (s_r.st == H_IDLE);
    assign rsp_valid    = s_r.rv;
    assign rsp_rdata    = s_r.rdata;
    assign b.sfr_wr     = (s_r.st == H_ACC) && s_r.we;
    assign b.sfr_rd     = (s_r.st == H_ACC) && !s_r.we;
    assign b.sfr_page   = s_r.page;
    assign b.sfr_addr   = s_r.addr;
    assign b.sfr_wdata  = s_r.wdata;
    assign b.req        = s_r.req;
    assign b.xfer_ready = xfer_ready;
    assign xfer_valid   = b.xfer_valid;
    assign xfer_chan    = b.xfer.chan;
    assign xfer_addr    = b.xfer.addr;
    assign irq          = b.irq;
endmodule

// File: core/dcs_if.sv
// Link between the CPU-side end and the channel control end.
// Both ends share clk; the bench joins them through this interface.
interface dcs_if
    import dcs_pkg::*;
    ();
    logic                sfr_wr;
    logic                sfr_rd;
    logic [PAGE_W-1:0]   sfr_page;
    logic [BYTE_W-1:0]   sfr_addr;
    logic [BYTE_W-1:0]   sfr_wdata;
    logic [BYTE_W-1:0]   sfr_rdata;
    logic [NCH-1:0]      req;
    logic                irq;
    logic                xfer_valid;
    logic                xfer_ready;
    dcs_xfer_s           xfer;

    modport dev (
        input  sfr_wr, sfr_rd, sfr_page, sfr_addr, sfr_wdata, req, xfer_ready,
        output sfr_rdata, irq, xfer_valid, xfer
    );
    modport host (
        output sfr_wr, sfr_rd, sfr_page, sfr_addr, sfr_wdata, req, xfer_ready,
        input  sfr_rdata, irq, xfer_valid, xfer
    );
endinterface

// File: core/dcs_pkg.sv
// Constants and types shared by both ends of the channel control block.
// Assumes one system clock and a synchronous active-high reset.
// Contract
// - Software configures channel in fixed order.
// - Wrap mode returns offset to zero.
// - Base address starts the transfer region.
// - Byte count bounds the transfer.
// - Software zeroes offset before enabling.
// - Enable bits 0..6; bit 7 zero.
// - Full flag when offset equals size-1.
// - Mid flag at half size, rounded up.
// - Flags stay set until software clears.
// - Config bit 7 enables full interrupt.
// - Config bit 6 enables mid interrupt.
// - Busy bit shows transfer in progress.
// - Writing busy 1 forces a start.
// - Registers on page 2, reset zero.
// - Selector codes 0..6 valid, 7 invalid.
// - Offset advances per byte; address base+offset.
// - Size/base/offset writes ignored while busy.
// - Lowest-numbered requesting channel wins.
package dcs_pkg;
    localparam int NCH    = 7;
    localparam int CH_W   = 3;
    localparam int BYTE_W = 8;
    localparam int BASE_W = 12;
    localparam int CNT_W  = 10;
    localparam int PAGE_W = 4;

    localparam logic [PAGE_W-1:0] SFR_PAGE = 4'h2;

    localparam logic [BYTE_W-1:0] A_CFG   = 8'hc9;
    localparam logic [BYTE_W-1:0] A_BASEL = 8'hca;
    localparam logic [BYTE_W-1:0] A_BASEH = 8'hcb;
    localparam logic [BYTE_W-1:0] A_SIZEL = 8'hcc;
    localparam logic [BYTE_W-1:0] A_SIZEH = 8'hcd;
    localparam logic [BYTE_W-1:0] A_OFFL  = 8'hce;
    localparam logic [BYTE_W-1:0] A_OFFH  = 8'hcf;
    localparam logic [BYTE_W-1:0] A_SEL   = 8'hd1;
    localparam logic [BYTE_W-1:0] A_EN    = 8'hd2;
    localparam logic [BYTE_W-1:0] A_FULL  = 8'hd3;
    localparam logic [BYTE_W-1:0] A_MID   = 8'hd4;
    localparam logic [BYTE_W-1:0] A_BUSY  = 8'hd5;
    localparam logic [BYTE_W-1:0] A_MODE  = 8'hd6;

    localparam int CFG_INTEN  = 7;
    localparam int CFG_MINTEN = 6;
    localparam int CFG_STALL  = 5;
    localparam int MODE_WRAP  = 0;

    localparam logic [CH_W-1:0] SEL_INVALID = 3'h7;
    localparam logic [1:0]      BUF_DEPTH   = 2'h2;

    typedef struct packed {
        logic [CH_W-1:0]   chan;
        logic [BASE_W-1:0] addr;
    } dcs_xfer_s;
endpackage

// File: tb/dcs_chk.sv
// Concurrent checks on the link between host end and channel end.
// Instantiated once in tb_top beside the link interface.
module dcs_chk
    import dcs_pkg::*;
(
    input wire logic              clk,
    input wire logic              rst,
    input wire logic              sfr_wr,
    input wire logic              sfr_rd,
    input wire logic [PAGE_W-1:0] sfr_page,
    input wire logic [BYTE_W-1:0] sfr_addr,
    input wire logic [BYTE_W-1:0] sfr_rdata,
    input wire logic              irq,
    input wire logic              xfer_valid,
    input wire logic              xfer_ready,
    input wire dcs_xfer_s         xfer
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_stream_hold: assert property (xfer_valid && !xfer_ready |=> xfer_valid && $stable(xfer))
        else $error("stalled word changed");
    a_chan_valid: assert property (xfer_valid |-> xfer.chan != SEL_INVALID)
        else $error("word from invalid channel");
    a_read_bit7: assert property (sfr_rd && sfr_page == SFR_PAGE && sfr_addr inside {[A_EN:A_BUSY]}
        |=> !sfr_rdata[7])
        else $error("bit 7 read as one");
    a_unmapped_zero: assert property (sfr_rd && sfr_page == SFR_PAGE && sfr_addr == 8'hd0
        |=> sfr_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_reset_idle: assert property ($fell(rst) |-> !irq && !xfer_valid)
        else $error("not idle after reset");
    a_irq_fall: assert property ($fell(irq) |-> $past(sfr_wr))
        else $error("irq dropped without write");
    a_rdata_hold: assert property (!(sfr_rd && sfr_page == SFR_PAGE) |=> $stable(sfr_rdata))
        else $error("read data moved");
    a_strobe_pulse: assert property (sfr_wr || sfr_rd |=> !sfr_wr && !sfr_rd)
        else $error("strobe longer than one cycle");

    c_busy_write: cover property (sfr_wr && sfr_addr == A_BUSY);
    c_irq_rise: cover property ($rose(irq));
    c_stall_pop: cover property (xfer_valid && !xfer_ready ##1 xfer_valid && xfer_ready);
endmodule

// File: tb/tb_top.sv
// Joins host end and channel end through the link; drives user side.
// Inputs change on the falling edge of a 25 MHz clock.
module tb_top
    import dcs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic              clk, rst, cv, we, rv, xv, xr, irq, cr;
    logic [PAGE_W-1:0] pg;
    logic [7:0]        ad, wd, rd;
    logic [NCH-1:0]    pr;
    logic [CH_W-1:0]   xc;
    logic [11:0]       xa;
    int                bad_count, check_count;
`define CHK(n, e, a) begin check_count++; if ((a) !== (e)) begin bad_count++; \
    $display("MISMATCH %s exp %h got %h", n, e, a); end end

    dcs_if lk();
    dcs_dev dcs_dev_inst (.clk(clk), .rst(rst), .b(lk));
    dcs_host dcs_host_inst (.clk(clk), .rst(rst), .cmd_valid(cv), .cmd_we(we), .cmd_page(pg),
        .cmd_addr(ad), .cmd_wdata(wd), .cmd_ready(cr), .rsp_valid(rv), .rsp_rdata(rd), .periph_req(pr),
        .xfer_valid(xv), .xfer_ready(xr), .xfer_chan(xc), .xfer_addr(xa), .irq(irq), .b(lk));
    dcs_chk dcs_chk_inst (.clk(clk), .rst(rst), .sfr_wr(lk.sfr_wr), .sfr_rd(lk.sfr_rd),
        .sfr_page(lk.sfr_page), .sfr_addr(lk.sfr_addr), .sfr_rdata(lk.sfr_rdata), .irq(lk.irq),
        .xfer_valid(lk.xfer_valid), .xfer_ready(lk.xfer_ready), .xfer(lk.xfer));

    initial begin
        clk = 0;
        forever #20 clk = ~clk;
    end

    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    // One register access; returns once the response pulse is seen
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        @(negedge clk);
        cv = 1; we = w; ad = a; wd = d;
        @(negedge clk);
        cv = 0;
        `CHK("ready_low", 1'b0, cr);
        n = 0;
        while (rv !== 1'b1 && n < 8) begin
            @(negedge clk);
            n++;
        end
        if (rv !== 1'b1) begin
            `CHK("rsp", 1'b1, rv);
            close_out();
        end
        `CHK("ready", 1'b1, cr);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        acc(1'b1, a, d);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [7:0] e, input string n);
        acc(1'b0, a, 8'h00);
        `CHK(n, e, rd);
    endtask

    // Waits for a word, checks it, then takes it
    task automatic pop(input logic [2:0] c, input logic [11:0] a);
        for (int n = 0; n < 16; n++) begin
            @(negedge clk);
            if (xv === 1'b1) break;
            xr = 0;
        end
        if (xv !== 1'b1) begin
            `CHK("valid", 1'b1, xv);
            close_out();
        end
        `CHK("chan", c, xc);
        `CHK("addr", a, xa);
        xr = 1;
        @(negedge clk);
        xr = 0;
    endtask

    task automatic cfg(input logic [7:0] ch, c, m, bl, bh, sz);
        wr(A_SEL, ch);
        wr(A_CFG, c);
        wr(A_MODE, m);
        wr(A_BASEL, bl);
        wr(A_BASEH, bh);
        wr(A_SIZEL, sz);
        wr(A_SIZEH, 8'h00);
        wr(A_OFFL, 8'h00);
        wr(A_OFFH, 8'h00);
    endtask

    initial begin
        cv = 0; we = 0; pg = SFR_PAGE; ad = 0; wd = 0; pr = 0; xr = 0; rst = 1;
        bad_count = 0;
        check_count = 0;
        repeat (4) @(posedge clk);
        @(negedge clk) rst = 0;
        for (int i = 0; i < 4; i++) rdc(8'(A_EN + i), 8'h00, "reset");
        rdc(8'hd0, 8'h00, "unmapped");
        wr(A_EN, 8'hff);
        rdc(A_EN, 8'h7f, "en");
        pg = 4'h3;
        wr(A_EN, 8'h00);
        pg = SFR_PAGE;
        rdc(A_EN, 8'h7f, "page");
        wr(A_EN, 8'h00);
        cfg(8'h00, 8'h80, 8'h00, 8'h23, 8'h01, 8'h04);
        cfg(8'h02, 8'h40, 8'h01, 8'h00, 8'h02, 8'h02);
        wr(A_EN, 8'h05);
        $display("test setup done");
        // Sink stalled: two words fill the buffer, third start waits
        wr(A_BUSY, 8'h05);
        wr(A_BUSY, 8'h01);
        rdc(A_BUSY, 8'h01, "busy");
        wr(A_SEL, 8'h00);
        wr(A_BASEL, 8'h55);
        pop(3'h0, 12'h123);
        pop(3'h2, 12'h200);
        pop(3'h0, 12'h124);
        rdc(A_BUSY, 8'h00, "idle");
        $display("test stall done");
        wr(A_BUSY, 8'h01);
        pop(3'h0, 12'h125);
        rdc(A_FULL, 8'h00, "early");
        rdc(A_MID, 8'h01, "mid");
        `CHK("irq", 1'b0, irq);
        wr(A_BUSY, 8'h01);
        pop(3'h0, 12'h126);
        rdc(A_FULL, 8'h01, "full");
        `CHK("irq", 1'b1, irq);
        @(negedge clk) pr = 7'h04;
        @(negedge clk) pr = 7'h00;
        pop(3'h2, 12'h201);
        rdc(A_FULL, 8'h05, "full2");
        rdc(A_MID, 8'h05, "mid2");
        wr(A_FULL, 8'h00);
        `CHK("irq", 1'b1, irq);
        wr(A_MID, 8'h04);
        rdc(A_MID, 8'h04, "keep");
        wr(A_MID, 8'h00);
        `CHK("irq", 1'b0, irq);
        $display("test flags done");
        wr(A_BUSY, 8'h04);
        pop(3'h2, 12'h200);
        wr(A_SEL, 8'h07);
        rdc(A_CFG, 8'h00, "sel7");
        wr(A_SEL, 8'h02);
        rdc(A_CFG, 8'h40, "cfg");
        $display("test wrap done");
        // Stall bit holds a forced start pending until it is cleared
        wr(A_CFG, 8'h60);
        wr(A_BUSY, 8'h04);
        rdc(A_BUSY, 8'h04, "stalled");
        `CHK("stall", 1'b0, xv);
        wr(A_CFG, 8'h40);
        pop(3'h2, 12'h201);
        `CHK("irq", 1'b1, irq);
        $display("test stall bit done");
        // Reset in mid-run clears flags set by the last transfer
        @(negedge clk) rst = 1;
        repeat (2) @(negedge clk);
        rst = 0;
        `CHK("irq", 1'b0, irq);
        rdc(A_FULL, 8'h00, "rst_full");
        rdc(A_MID, 8'h00, "rst_mid");
        rdc(A_CFG, 8'h00, "rst_cfg");
        $display("test reset done");
        close_out();
    end
endmodule
